// [logic/mcuie_core.sv]
`timescale 1ns/100ps
`default_nettype none
module mcuie_core
   import mcuie_pkg::*;
#(
   parameter int unsigned DMEM_DEPTH = 256,
   parameter int unsigned STACK_DEPTH = 8
)(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // instruction fetch
   input wire mcuie_instr_type instr_i,
   output logic [PC_W-1:0] pc_o,
   output logic exec_o,
   // architectural state
   output logic [7:0] acc_o,
   output mcuie_flags_type flags_o,
   // power-down and watchdog
   input wire logic wake_i,
   output logic halted_o,
   output logic wdt_clear_o,
   // program memory table port
   output logic [PC_W-1:0] tbl_addr_o,
   input wire logic [15:0] tbl_data_i,
   output logic [7:0] tbl_high_o,
   // data memory debug port
   input wire logic dbg_we_i,
   input wire logic [7:0] dbg_addr_i,
   input wire logic [7:0] dbg_wdata_i,
   output logic [7:0] dbg_rdata_o
);
   localparam int unsigned SP_W = $clog2(STACK_DEPTH);

   //////////////////////////////////////////////////////////////////////////
   // state
   logic [1:0] phase_r; // position within the instruction cycle
   logic [PC_W-1:0] pc_r;
   logic [7:0] acc_r; // working_register
   mcuie_flags_type flags_r;
   logic busy_r; // extra instruction cycle in progress
   logic halted_r;
   logic wdt_clear_r;
   logic exec_r; // pulse after each executed instruction
   logic tbl_pend_r; // table data due at end of extra cycle
   logic [7:0] tbl_dst_r;
   logic [PC_W-1:0] tbl_addr_r;
   logic [7:0] tbl_high_r;
   logic [7:0] dbg_rdata_r;
   logic [SP_W-1:0] sp_r;
   // helpers that describe the last executed instruction
   mcuie_op_type last_op_r;
   logic two_r;
   logic skip_r;
   logic pclo_wr_r;
   logic [7:0] last_res_r;
   // sector 0 data memory and return stack, no reset needed
   logic [7:0] dmem [DMEM_DEPTH];
   logic [PC_W-1:0] stack [STACK_DEPTH];

   //////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic is_branch(input mcuie_op_type op);
      is_branch = (op == OP_GOTO) || (op == OP_CALL) || (op == OP_RTN) ||
                  (op == OP_RTNI) || (op == OP_TABRD);
   endfunction : is_branch

   function automatic logic is_pop(input mcuie_op_type op);
      is_pop = (op == OP_RTN) || (op == OP_RTNI);
   endfunction : is_pop

   //////////////////////////////////////////////////////////////////////////
   // cycle framing and operand selection
   wire tick_w = (phase_r == PHASE_LAST);
   wire run_w = tick_w && !busy_r && !halted_r;
   mcuie_op_type op_w;
   assign op_w = instr_i.op;
   // only an 8-bit address exists, so sector 0 is all that is reached
   wire [7:0] maddr_w = instr_i.addr;
   // the counter low byte reads back live rather than from memory
   wire [7:0] mrd_w = (maddr_w == PC_LOW_ADDR) ? pc_r[7:0] : dmem[maddr_w];
   wire [7:0] b_w = instr_i.use_imm ? instr_i.imm : mrd_w;
   wire [SP_W-1:0] sp_dec_w = sp_r - SP_W'(1);
   wire [PC_W-1:0] pc_inc_w = pc_r + PC_ONE;

   //////////////////////////////////////////////////////////////////////////
   // adder and subtractor, nine bits so carry and borrow fall out
   wire cin_w = (op_w == OP_ADC) && flags_r.c;
   wire bin_w = (op_w == OP_SBC) && !flags_r.c;
   wire [8:0] sum_w = {1'b0, acc_r} + {1'b0, b_w} + {8'h00, cin_w};
   wire [4:0] sum_lo_w = {1'b0, acc_r[3:0]} + {1'b0, b_w[3:0]} +
                         {4'h0, cin_w};
   wire [8:0] dif_w = {1'b0, acc_r} - {1'b0, b_w} - {8'h00, bin_w};
   wire [4:0] dif_lo_w = {1'b0, acc_r[3:0]} - {1'b0, b_w[3:0]} -
                         {4'h0, bin_w};
   wire add_ovf_w = (acc_r[7] == b_w[7]) && (sum_w[7] != acc_r[7]);
   wire sub_ovf_w = (acc_r[7] != b_w[7]) && (dif_w[7] != acc_r[7]);
   // decimal adjust of the working register
   wire dadj_lo_w = (acc_r[3:0] > 4'h9) || flags_r.aux;
   wire [8:0] dadj_t_w = {1'b0, acc_r} + (dadj_lo_w ? 9'h006 : 9'h000);
   wire dadj_hi_w = dadj_t_w[8] || (dadj_t_w[7:4] > 4'h9) || flags_r.c;
   wire [7:0] dadj_w = dadj_t_w[7:0] + (dadj_hi_w ? 8'h60 : 8'h00);
   wire [7:0] inc_w = b_w + 8'h01;
   wire [7:0] dec_w = b_w - 8'h01;

   //////////////////////////////////////////////////////////////////////////
   // result, flags and write targets of the current instruction
   logic [7:0] res_nxt;
   mcuie_flags_type fl_nxt;
   logic wr_mem_nxt;
   logic wr_acc_nxt;
   logic skip_nxt;
   always_comb
   begin
      // untouched flags carry over by default
      res_nxt = b_w;
      fl_nxt = flags_r;
      wr_mem_nxt = 1'b0;
      wr_acc_nxt = 1'b0;
      skip_nxt = 1'b0;
      case (op_w)
         OP_ADD, OP_ADC:
         begin
            res_nxt = sum_w[7:0];
            fl_nxt.c = sum_w[8];
            fl_nxt.aux = sum_lo_w[4];
            fl_nxt.ovf = add_ovf_w;
            fl_nxt.scmp = add_ovf_w ^ sum_w[7];
            fl_nxt.z = (sum_w[7:0] == 8'h00);
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         OP_SUB, OP_SBC:
         begin
            // carry set means no borrow
            res_nxt = dif_w[7:0];
            fl_nxt.c = !dif_w[8];
            fl_nxt.aux = !dif_lo_w[4];
            fl_nxt.ovf = sub_ovf_w;
            fl_nxt.scmp = sub_ovf_w ^ dif_w[7];
            fl_nxt.z = (dif_w[7:0] == 8'h00);
            // compare-zero chains through multi-byte borrow subtracts
            fl_nxt.czf = (dif_w[7:0] == 8'h00) &&
                        ((op_w == OP_SUB) || flags_r.z);
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         OP_DECADJ:
         begin
            res_nxt = dadj_w;
            fl_nxt.c = dadj_hi_w;
            wr_mem_nxt = 1'b1;
         end
         OP_AND, OP_OR, OP_XOR, OP_INV:
         begin
            if (op_w == OP_AND)
               res_nxt = acc_r & b_w;
            else if (op_w == OP_OR)
               res_nxt = acc_r | b_w;
            else if (op_w == OP_XOR)
               res_nxt = acc_r ^ b_w;
            else
               res_nxt = ~b_w;
            fl_nxt.z = (res_nxt == 8'h00);
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         OP_INC, OP_DEC:
         begin
            res_nxt = (op_w == OP_INC) ? inc_w : dec_w;
            fl_nxt.z = (res_nxt == 8'h00);
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         OP_RR, OP_RL, OP_RRCY, OP_RLCY:
         begin
            // plain rotates leave every flag alone
            if (op_w == OP_RR)
               res_nxt = {b_w[0], b_w[7:1]};
            else if (op_w == OP_RL)
               res_nxt = {b_w[6:0], b_w[7]};
            else if (op_w == OP_RRCY)
            begin
               res_nxt = {flags_r.c, b_w[7:1]};
               fl_nxt.c = b_w[0];
            end
            else
            begin
               res_nxt = {b_w[6:0], flags_r.c};
               fl_nxt.c = b_w[7];
            end
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         OP_MOVA:
            wr_acc_nxt = 1'b1;
         OP_MOVM:
         begin
            res_nxt = acc_r;
            wr_mem_nxt = 1'b1;
         end
         OP_BCLR, OP_BSET:
         begin
            // read-modify-write on the single indexed bit
            res_nxt = mrd_w;
            res_nxt[instr_i.bitn] = (op_w == OP_BSET);
            wr_mem_nxt = 1'b1;
         end
         OP_CLRM, OP_SETM:
         begin
            res_nxt = (op_w == OP_SETM) ? 8'hFF : 8'h00;
            wr_mem_nxt = 1'b1;
         end
         OP_SWAP:
         begin
            res_nxt = {b_w[3:0], b_w[7:4]};
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         OP_SZ, OP_SNZ, OP_SZB, OP_SNZB:
         begin
            // for SZ and SNZ, clear to_mem also copies the tested byte to the register
            if (op_w == OP_SZ)
               skip_nxt = (b_w == 8'h00);
            else if (op_w == OP_SNZ)
               skip_nxt = (b_w != 8'h00);
            else if (op_w == OP_SZB)
               skip_nxt = !b_w[instr_i.bitn];
            else
               skip_nxt = b_w[instr_i.bitn];
            wr_acc_nxt = !instr_i.to_mem && (op_w != OP_SZB) &&
                         (op_w != OP_SNZB);
         end
         OP_SIZ, OP_SDZ:
         begin
            res_nxt = (op_w == OP_SIZ) ? inc_w : dec_w;
            skip_nxt = (res_nxt == 8'h00);
            wr_mem_nxt = instr_i.to_mem;
            wr_acc_nxt = !instr_i.to_mem;
         end
         default:
            res_nxt = b_w;
      endcase
   end

   // writing the counter low byte is an implicit jump
   wire pclo_wr_w = wr_mem_nxt && (maddr_w == PC_LOW_ADDR);
   wire two_w = is_branch(op_w) || pclo_wr_w || skip_nxt;

   //////////////////////////////////////////////////////////////////////////
   // program counter
   logic [PC_W-1:0] pc_nxt;
   always_comb
   begin
      if (op_w == OP_GOTO || op_w == OP_CALL)
         pc_nxt = instr_i.target;
      else if (is_pop(op_w))
         pc_nxt = stack[sp_dec_w];
      else if (pclo_wr_w)
         pc_nxt = {pc_r[PC_W-1:8], res_nxt};
      else if (skip_nxt)
         pc_nxt = pc_r + PC_TWO;
      else
         pc_nxt = pc_inc_w;
   end

   //////////////////////////////////////////////////////////////////////////
   // phase divider: one tick every four clocks
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         phase_r <= 2'h0;
      else
         phase_r <= phase_r + 2'h1;
   end

   // architectural registers update once per executed instruction
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pc_r <= PC_RST;
         acc_r <= WREG_RST;
         flags_r <= FLAGS_RST;
         sp_r <= '0;
      end
      else if (run_w)
      begin
         pc_r <= pc_nxt;
         flags_r <= fl_nxt;
         if (wr_acc_nxt)
            acc_r <= res_nxt;
         // stack wraps silently when nested too deep
         if (op_w == OP_CALL)
            sp_r <= sp_r + SP_W'(1);
         else if (is_pop(op_w))
            sp_r <= sp_dec_w;
      end
   end

   // extra-cycle, power-down, watchdog and table control
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         busy_r <= 1'b0;
         halted_r <= 1'b0;
         wdt_clear_r <= 1'b0;
         tbl_pend_r <= 1'b0;
         tbl_dst_r <= 8'h00;
         tbl_addr_r <= PC_RST;
         tbl_high_r <= 8'h00;
      end
      else
      begin
         wdt_clear_r <= run_w && (op_w == OP_CLRWDT);
         if (halted_r && wake_i)
            halted_r <= 1'b0;
         else if (run_w && (op_w == OP_HALT))
            halted_r <= 1'b1;
         if (run_w)
            busy_r <= two_w;
         else if (tick_w)
            busy_r <= 1'b0;
         if (run_w && (op_w == OP_TABRD))
         begin
            // data has a whole instruction cycle to come back
            tbl_addr_r <= {pc_r[PC_W-1:8], instr_i.imm};
            tbl_dst_r <= maddr_w;
            tbl_pend_r <= 1'b1;
         end
         else if (tick_w && busy_r && tbl_pend_r)
         begin
            tbl_high_r <= tbl_data_i[15:8];
            tbl_pend_r <= 1'b0;
         end
      end
   end

   // data memory; core writes win over the debug port
   always_ff @(posedge core_clk_i)
   begin
      if (run_w && wr_mem_nxt)
         dmem[maddr_w] <= res_nxt;
      else if (tick_w && busy_r && tbl_pend_r)
         dmem[tbl_dst_r] <= tbl_data_i[7:0];
      else if (dbg_we_i)
         dmem[dbg_addr_i] <= dbg_wdata_i;
   end

   // return stack holds the address after the call
   always_ff @(posedge core_clk_i)
   begin
      if (run_w && (op_w == OP_CALL))
         stack[sp_r] <= pc_inc_w;
   end

   // observation registers
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         exec_r <= 1'b0;
         last_op_r <= OP_NOP;
         two_r <= 1'b0;
         skip_r <= 1'b0;
         pclo_wr_r <= 1'b0;
         last_res_r <= 8'h00;
         dbg_rdata_r <= 8'h00;
      end
      else
      begin
         exec_r <= run_w;
         dbg_rdata_r <= dmem[dbg_addr_i];
         if (run_w)
         begin
            last_op_r <= op_w;
            two_r <= two_w;
            skip_r <= skip_nxt;
            pclo_wr_r <= pclo_wr_w;
            last_res_r <= res_nxt;
         end
      end
   end

   assign pc_o = pc_r;
   assign exec_o = exec_r;
   assign acc_o = acc_r;
   assign flags_o = flags_r;
   assign halted_o = halted_r;
   assign wdt_clear_o = wdt_clear_r;
   assign tbl_addr_o = tbl_addr_r;
   assign tbl_high_o = tbl_high_r;
   assign dbg_rdata_o = dbg_rdata_r;

   //////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   a_tick_period: assert property (tick_w |=> !tick_w [*3] ##1 tick_w)
      else $error("tick spacing is not four clocks");
   a_single_cycle: assert property (exec_r && !two_r && !halted_r |=>
      !exec_r [*3] ##1 exec_r)
      else $error("one-cycle instruction took wrong time");
   a_double_cycle: assert property (exec_r && two_r && !halted_r |=>
      !exec_r [*7] ##1 exec_r)
      else $error("two-cycle instruction took wrong time");
   a_pclo_extra: assert property (exec_r && pclo_wr_r |-> two_r)
      else $error("counter low write did not add a cycle");
   a_skip_pc: assert property (exec_r && skip_r |->
      pc_r == $past(pc_r) + PC_TWO)
      else $error("taken skip did not pass one instruction");
   a_call_push: assert property (exec_r && last_op_r == OP_CALL |->
      stack[sp_dec_w] == $past(pc_r) + PC_ONE)
      else $error("call saved wrong return point");
   a_logic_flags: assert property (exec_r && (last_op_r == OP_AND ||
      last_op_r == OP_XOR) |-> flags_r.z == (last_res_r == 8'h00) &&
      {flags_r.c, flags_r.aux, flags_r.ovf} ==
      $past({flags_r.c, flags_r.aux, flags_r.ovf}))
      else $error("logic op disturbed flags");
   a_rotate_flags: assert property (exec_r && (last_op_r == OP_RR ||
      last_op_r == OP_RL) |-> $stable(flags_r))
      else $error("plain rotate changed flags");
   a_add_zero: assert property (exec_r && last_op_r == OP_ADD |->
      flags_r.z == (last_res_r == 8'h00))
      else $error("add zero flag wrong");
   a_halt_stops: assert property (exec_r && last_op_r == OP_HALT |->
      halted_r)
      else $error("halt did not power down");

   c_jump: cover property (exec_r && last_op_r == OP_GOTO);
   c_skip: cover property (exec_r && skip_r);
   c_call_ret: cover property (exec_r && last_op_r == OP_CALL ##[4:200]
      exec_r && last_op_r == OP_RTN);
   c_table: cover property (exec_r && last_op_r == OP_TABRD);
endmodule : mcuie_core
`default_nettype wire

// [logic/mcuie_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Contract
// - instruction cycle is four system clocks
// - ordinary one cycle; jump/call/return/table two
// - program counter low byte write adds a cycle
// - skip costs one extra cycle only when taken
// - skip tests memory byte or bit, suppresses next
// - call saves return point; jump saves none
// - bit set/clear touches only selected bit
// - add updates zero, carry, aux, overflow, signed
// - subtract also updates compare-zero flag
// - eight-bit arithmetic; carry above 255, borrow below 0
// - logic ops affect only zero flag
// - increment/decrement by one, only zero flag
// - plain rotate no flags; through-carry only carry
// - decimal adjust to memory, only carry changes
// - table read fetches program memory data
// - data memory reach limited to sector 0
// - halt powers down; watchdog clear instruction
//////////////////////////////////////////////////////////////////////////////
package mcuie_pkg;
   // instruction cycle framing
   localparam int unsigned CLKS_PER_CYC = 4;
   localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_CYC - 1);
   // program counter and data memory geometry
   localparam int unsigned PC_W = 12;
   localparam logic [PC_W-1:0] PC_RST = 12'h000;
   localparam logic [PC_W-1:0] PC_ONE = 12'h001;
   localparam logic [PC_W-1:0] PC_TWO = 12'h002;
   localparam logic [7:0] PC_LOW_ADDR = 8'h06;
   localparam logic [7:0] WREG_RST = 8'h00;
   localparam logic [15:0] TBL_RST = 16'h0000;

   // operation set of sector 0
   typedef enum logic [5:0] {
      OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DECADJ,
      OP_AND, OP_OR, OP_XOR, OP_INV, OP_INC, OP_DEC,
      OP_RR, OP_RL, OP_RRCY, OP_RLCY, OP_MOVA, OP_MOVM,
      OP_BCLR, OP_BSET, OP_CLRM, OP_SETM, OP_SWAP,
      OP_SZ, OP_SNZ, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ,
      OP_GOTO, OP_CALL, OP_RTN, OP_RTNI, OP_TABRD,
      OP_HALT, OP_CLRWDT
   } mcuie_op_type;

   // decoded instruction as presented at the current program counter
   typedef struct packed {
      mcuie_op_type op;
      logic use_imm;
      logic to_mem;
      logic [7:0] addr;
      logic [2:0] bitn;
      logic [7:0] imm;
      logic [PC_W-1:0] target;
   } mcuie_instr_type;

   // status flags
   typedef struct packed {
      logic z;
      logic c;
      logic aux;
      logic ovf;
      logic scmp;
      logic czf;
   } mcuie_flags_type;

   localparam mcuie_flags_type FLAGS_RST = '0;
endpackage : mcuie_pkg

// [test/tb_mcu_core_instruction_execution.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_core_instruction_execution
   import mcuie_pkg::*;
;
   // stimulus side
   logic core_clk_i, rstn_i, wake_i, dbg_we_i;
   mcuie_instr_type instr_i;
   logic [7:0] dbg_addr_i, dbg_wdata_i;
   logic [15:0] tbl_data_i = 16'hA55A; // fixed table word
   // observed side
   logic [PC_W-1:0] pc_o, tbl_addr_o, p;
   logic exec_o, halted_o, wdt_clear_o;
   logic [7:0] acc_o, tbl_high_o, dbg_rdata_o;
   mcuie_flags_type flags_o;
   // bookkeeping
   int n_mismatch = 0, tests_run = 0, n_exec = 0, n_wdt = 0, n;

   mcuie_core u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .instr_i(instr_i), .pc_o(pc_o), .exec_o(exec_o), .acc_o(acc_o),
      .flags_o(flags_o), .wake_i(wake_i), .halted_o(halted_o),
      .wdt_clear_o(wdt_clear_o), .tbl_addr_o(tbl_addr_o),
      .tbl_data_i(tbl_data_i), .tbl_high_o(tbl_high_o),
      .dbg_we_i(dbg_we_i), .dbg_addr_i(dbg_addr_i),
      .dbg_wdata_i(dbg_wdata_i), .dbg_rdata_o(dbg_rdata_o));

   ////////////////////////////////////////////////////////////////////////////
   // clock and pulse counters
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // pulses last one clock, so count them rather than catch them
   always @(posedge core_clk_i)
   begin
      if (exec_o === 1'b1) n_exec <= n_exec + 1;
      if (wdt_clear_o === 1'b1) n_wdt <= n_wdt + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   function automatic mcuie_instr_type mk(mcuie_op_type o, logic m,
      logic [7:0] a, logic [2:0] b, logic [7:0] x, logic [PC_W-1:0] t);
      mk = '{o, 1'b0, m, a, b, x, t};
   endfunction : mk

   // immediate forms set use_imm
   function automatic mcuie_instr_type ai(mcuie_op_type o, logic [7:0] x);
      ai = '{o, 1'b1, 1'b0, 8'h00, 3'h0, x, 12'h000};
   endfunction : ai

   // present one instruction, wait for its execution, bounded
   task automatic run(input mcuie_instr_type ins, output int c);
      instr_i = ins;
      c = 0;
      do
      begin
         @(posedge core_clk_i);
         #1;
         c++;
      end while (exec_o !== 1'b1 && c < 40);
      if (c >= 40) check(16'h0, 16'h1); // hang guard
   endtask : run

   // a trailing no-op exposes the instruction's length in clocks
   task automatic go(input mcuie_instr_type ins, input int len);
      run(ins, n);
      run(mk(OP_NOP, 0, 0, 0, 0, 0), n);
      check(n, 4 * len);
   endtask : go

   task automatic ck_af(input logic [7:0] a, input logic [5:0] f);
      check(acc_o, a);
      check(flags_o, f);
   endtask : ck_af

   // debug port: core only runs no-ops here, so no write collision
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      dbg_addr_i = a;
      dbg_wdata_i = d;
      dbg_we_i = 1'b1;
      @(posedge core_clk_i);
      #1 dbg_we_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      dbg_addr_i = a;
      repeat (2) @(posedge core_clk_i);
      #1 check(dbg_rdata_o, e);
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////
   // scenarios; flag vectors are {z,c,ac,ov,sc,cz}
   task automatic t_arith;
      go(ai(OP_ADD, 8'h7F), 1);
      ck_af(8'h7F, 6'b000000);
      go(ai(OP_ADD, 8'h01), 1);
      ck_af(8'h80, 6'b001100);
      go(ai(OP_ADD, 8'h80), 1);
      ck_af(8'h00, 6'b110110);
      go(ai(OP_SUB, 8'h01), 1);
      ck_af(8'hFF, 6'b000010);
      go(ai(OP_SUB, 8'hFF), 1);
      ck_af(8'h00, 6'b111001);
      go(ai(OP_AND, 8'h00), 1);
      ck_af(8'h00, 6'b111001);
      go(ai(OP_OR, 8'h5A), 1);
      ck_af(8'h5A, 6'b011001);
      go(ai(OP_XOR, 8'h5A), 1);
      ck_af(8'h00, 6'b111001);
      go(ai(OP_ADC, 8'h01), 1);
      ck_af(8'h02, 6'b000001);
      // compare-zero also needs the zero flag from before
      go(ai(OP_SBC, 8'h01), 1);
      ck_af(8'h00, 6'b111000);
   endtask : t_arith

   task automatic t_memory;
      wr(8'h20, 8'h0F);
      go(mk(OP_INV, 1, 8'h20, 0, 0, 0), 1);
      rd(8'h20, 8'hF0);
      ck_af(8'h00, 6'b011000);
      go(mk(OP_INC, 1, 8'h20, 0, 0, 0), 1);
      rd(8'h20, 8'hF1);
      go(mk(OP_SWAP, 1, 8'h20, 0, 0, 0), 1);
      rd(8'h20, 8'h1F);
      wr(8'h30, 8'h01);
      go(mk(OP_DEC, 0, 8'h30, 0, 0, 0), 1);
      ck_af(8'h00, 6'b111000);
      rd(8'h30, 8'h01);
   endtask : t_memory

   task automatic t_rotate;
      wr(8'h21, 8'h81);
      go(mk(OP_RR, 0, 8'h21, 0, 0, 0), 1);
      ck_af(8'hC0, 6'b111000);
      wr(8'h22, 8'h02);
      go(mk(OP_RRCY, 0, 8'h22, 0, 0, 0), 1);
      ck_af(8'h81, 6'b101000);
      wr(8'h23, 8'h80);
      go(mk(OP_RLCY, 1, 8'h23, 0, 0, 0), 1);
      rd(8'h23, 8'h00);
      go(mk(OP_RL, 1, 8'h21, 0, 0, 0), 1);
      rd(8'h21, 8'h03);
      ck_af(8'h81, 6'b111000);
   endtask : t_rotate

   task automatic t_decimal;
      go(ai(OP_AND, 8'h00), 1);
      go(ai(OP_ADD, 8'hA0), 1);
      go(mk(OP_DECADJ, 1, 8'h24, 0, 0, 0), 1);
      rd(8'h24, 8'h00);
      ck_af(8'hA0, 6'b010010);
   endtask : t_decimal

   task automatic t_bits;
      wr(8'h26, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         go(mk(OP_BSET, 1, 8'h26, 3'(i), 0, 0), 1);
         rd(8'h26, 8'((9'h001 << (i + 1)) - 9'h001));
      end
      go(mk(OP_BCLR, 1, 8'h26, 3'h3, 0, 0), 1);
      rd(8'h26, 8'hF7);
   endtask : t_bits

   task automatic t_table;
      p = pc_o;
      go(mk(OP_TABRD, 1, 8'h27, 0, 8'h34, 0), 2);
      check(tbl_addr_o, {p[11:8], 8'h34});
      check(tbl_high_o, 8'hA5);
      rd(8'h27, 8'h5A);
   endtask : t_table

   // a taken skip costs one more cycle and one more address
   task automatic sk(input mcuie_instr_type ins, input int tk);
      p = pc_o;
      go(ins, 1 + tk);
      check(pc_o, p + 12'(2 + tk));
   endtask : sk

   task automatic t_skip;
      wr(8'h28, 8'h00);
      wr(8'h29, 8'h10);
      sk(mk(OP_SZ, 1, 8'h29, 0, 0, 0), 0);
      sk(mk(OP_SZ, 1, 8'h28, 0, 0, 0), 1);
      sk(mk(OP_SNZB, 1, 8'h29, 3'h4, 0, 0), 1);
      sk(mk(OP_SZB, 1, 8'h29, 3'h4, 0, 0), 0);
      sk(mk(OP_SNZ, 1, 8'h28, 0, 0, 0), 0);
      wr(8'h2A, 8'h01);
      sk(mk(OP_SDZ, 1, 8'h2A, 0, 0, 0), 1);
      rd(8'h2A, 8'h00);
      wr(8'h2B, 8'hFF);
      sk(mk(OP_SIZ, 0, 8'h2B, 0, 0, 0), 1);
      check(acc_o, 8'h00);
   endtask : t_skip

   task automatic t_branch;
      go(mk(OP_GOTO, 0, 0, 0, 0, 12'h100), 2);
      check(pc_o, 12'h101);
      p = pc_o;
      go(mk(OP_CALL, 0, 0, 0, 0, 12'h200), 2);
      check(pc_o, 12'h201);
      go(mk(OP_RTN, 0, 0, 0, 0, 0), 2);
      check(pc_o, p + 12'h002);
      p = pc_o;
      go(mk(OP_CLRM, 1, PC_LOW_ADDR, 0, 0, 0), 2);
      check(pc_o, {p[11:8], 8'h01});
   endtask : t_branch

   task automatic t_power;
      int k;
      k = n_wdt;
      go(mk(OP_CLRWDT, 0, 0, 0, 0, 0), 1);
      check(n_wdt, k + 1);
      run(mk(OP_HALT, 0, 0, 0, 0, 0), n);
      instr_i = mk(OP_NOP, 0, 0, 0, 0, 0);
      k = n_exec;
      repeat (12) @(posedge core_clk_i);
      #1 check(halted_o, 1'b1);
      // the halt's own pulse is counted one clock after run returns
      check(n_exec, k + 1);
      wake_i = 1'b1;
      @(posedge core_clk_i);
      #1 wake_i = 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1 check(halted_o, 1'b0);
      run(mk(OP_NOP, 0, 0, 0, 0, 0), n);
   endtask : t_power

   ////////////////////////////////////////////////////////////////////////////
   // verdict, main sequence and watchdog
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      rstn_i = 1'b0;
      wake_i = 1'b0;
      dbg_we_i = 1'b0;
      dbg_addr_i = 8'h00;
      dbg_wdata_i = 8'h00;
      instr_i = mk(OP_NOP, 0, 0, 0, 0, 0);
      repeat (8) @(posedge core_clk_i);
      #1 rstn_i = 1'b1;
      run(mk(OP_NOP, 0, 0, 0, 0, 0), n);
      check(n, 4);
      t_arith();
      t_memory();
      t_rotate();
      t_decimal();
      t_bits();
      t_table();
      t_skip();
      t_branch();
      t_power();
      tally_and_finish();
   end

   // the whole run needs well under a thousand clocks; cut it off well beyond
   initial
   begin
      #400000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb_mcu_core_instruction_execution
`default_nettype wire
